// >>> src/wdt_cycle_counter.v
`timescale 1ns/10ps
`default_nettype none

// Free-running divider: pulses tick_o every LIMIT enabled cycles
module wdt_cycle_counter #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] LIMIT = 16'd49152
) (
  input wire clk_i,
  input wire rstn_i,
  input wire en_i,
  input wire restart_i,
  output wire tick_o
);
  reg [WIDTH-1:0] cnt_r;

  // Terminal count when reaching LIMIT-1
  assign tick_o = en_i && !restart_i && (cnt_r == LIMIT - {{(WIDTH-1){1'b0}}, 1'b1});

  // Restart wins so a reload gets a full first step
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= {WIDTH{1'b0}};
    end else if (restart_i) begin
      cnt_r <= {WIDTH{1'b0}};
    end else if (en_i) begin
      if (tick_o) begin
        cnt_r <= {WIDTH{1'b0}};
      end else begin
        cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // wdt_cycle_counter

`default_nettype wire

// >>> src/wdt_defs.vh
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// Register map: control word at byte 0x0c, status word at 0x10
`define WDT_CTRL_OFFS 12'h00c
`define WDT_STAT_OFFS 12'h010

// Control field layout
`define WDT_ACT_BIT 7
`define WDT_TOP_BIT 6
`define WDT_CNT_MSB 6
`define WDT_CTRL_RESET 8'h7f

// Counter rates
`define WDT_PRESCALE_CYCLES 49152
`define WDT_HALT_WAKE_CLOCKS 4096

// Reset pulse width, nanoseconds, and clock period
`define WDT_RST_PULSE_NS 30000
`define WDT_CLK_PERIOD_NS 4

// AXI responses
`define WDT_RESP_OKAY 2'b00
`define WDT_RESP_SLVERR 2'b10

`endif

// >>> src/wdt_top.v
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"

// Behaviour
// - Count field decrements once every 49,152 machine cycles.
// - Lower six count bits choose timeout in 64 steps.
// - Active and count 40h to 3Fh starts low reset pulse, about 30us.
// - Counter keeps decrementing even while watchdog is inactive.
// - At 8 MHz, FFh gives 393.216 ms, C0h gives 6.144 ms.
// - Inactive after reset; once active, only reset deactivates it.
// - Writing activation set with top count bit clear forces reset.
// - Hardware option makes watchdog always active, activation bit ignored.
// - Reset-on-halt option plus active watchdog: halt resets at once.
// - Otherwise halt freezes counter, no reset until wake or reset.
// - External-interrupt wake resumes counting 4096 clocks later.
// - Control holds activation in bit 7, count in bits 6..0.
// - Control resets to 7Fh.
module wdt_top #(
  parameter PRESCALE = `WDT_PRESCALE_CYCLES,
  parameter WAKE_DELAY = `WDT_HALT_WAKE_CLOCKS,
  parameter PULSE_NS = `WDT_RST_PULSE_NS
) (
  input wire clk_i,
  input wire rstn_i,
  input wire clk_en_i,
  // Option-byte straps
  input wire opt_hw_watchdog_i,
  input wire opt_reset_on_halt_i,
  // Power control
  input wire halt_i,
  input wire ext_wake_i,
  // AXI4-Lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reset request, low while asserted
  output reg wdt_rst_n_o,
  output wire wdt_active_o
);
  localparam PULSE_CYC = (PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS;

  // Sized copies so word-index compares and reset loads match widths
  localparam [11:0] CTRL_ADDR = `WDT_CTRL_OFFS;
  localparam [11:0] STAT_ADDR = `WDT_STAT_OFFS;
  localparam [7:0] CTRL_RST = `WDT_CTRL_RESET;

  // Power states
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_HALT = 2'b01;
  localparam [1:0] ST_WAKE = 2'b10;

  reg act_r;
  reg [6:0] cnt_r;
  reg [1:0] pst_r;
  reg [12:0] wake_r;
  reg [15:0] pulse_r;
  reg aw_r;
  reg [11:0] awaddr_r;
  reg w_r;
  reg [7:0] wdata_r;
  reg wstrb0_r;

  wire tick;
  wire running;
  wire active;
  wire wr_go;
  wire wr_ctrl;
  wire expire;
  wire force_rst;
  wire halt_rst;
  wire trigger;
  wire [6:0] cnt_dec;

  // Address decode, shared by both channels
  function is_ctrl;
    input [11:0] a;
    begin
      is_ctrl = (a[11:2] == CTRL_ADDR[11:2]);
    end
  endfunction

  function is_stat;
    input [11:0] a;
    begin
      is_stat = (a[11:2] == STAT_ADDR[11:2]);
    end
  endfunction

  // Hardware option overrides the activation bit
  // forced activation
  assign active = act_r | opt_hw_watchdog_i;
  assign wdt_active_o = active;

  // Counter only runs with the oscillator on
  // frozen in halt
  assign running = clk_en_i && (pst_r == ST_RUN);

  // timeout is steps times PRESCALE cycles
  wdt_cycle_counter #(
    .WIDTH(16),
    .LIMIT(PRESCALE[15:0])
  ) u_presc (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(running),
    .restart_i(wr_ctrl),
    .tick_o(tick)
  );

  // Write handshake: address and data may arrive in either order
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready = !w_r && !s_axi_bvalid;
  assign wr_go = clk_en_i && aw_r && w_r && !s_axi_bvalid;
  assign wr_ctrl = wr_go && is_ctrl(awaddr_r) && wstrb0_r;
  assign cnt_dec = cnt_r - 7'h01;

  assign expire = running && tick && (cnt_r == 7'h40);
  assign force_rst = wr_ctrl && (wdata_r[`WDT_ACT_BIT] | opt_hw_watchdog_i | act_r)
    && !wdata_r[`WDT_TOP_BIT];
  assign halt_rst = clk_en_i && halt_i && opt_reset_on_halt_i && (pst_r == ST_RUN);
  assign trigger = (active && (expire || halt_rst)) || force_rst;

  // Write channel capture
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_r <= 1'b0;
      awaddr_r <= 12'h000;
      w_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDT_RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status word is read-only; writes there are accepted and ignored
        s_axi_bresp <= (is_ctrl(awaddr_r) || is_stat(awaddr_r)) ?
          `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `WDT_RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `WDT_RESP_OKAY;
        if (is_ctrl(s_axi_araddr)) begin
          s_axi_rdata <= {24'h000000, act_r, cnt_r};
        end else if (is_stat(s_axi_araddr)) begin
          s_axi_rdata <= {28'h0000000, !wdt_rst_n_o, pst_r, active};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `WDT_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control register and count
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_r <= CTRL_RST[`WDT_ACT_BIT];
      cnt_r <= CTRL_RST[`WDT_CNT_MSB:0];
    end else if (wr_ctrl) begin
      // activation is sticky, a low write cannot clear it
      act_r <= act_r | wdata_r[`WDT_ACT_BIT];
      // full count load, low six bits set delay
      cnt_r <= wdata_r[`WDT_CNT_MSB:0];
    end else if (running && tick) begin
      cnt_r <= cnt_dec;
    end
  end

  // Power-state sequencing around halt
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pst_r <= ST_RUN;
      wake_r <= 13'h0000;
    end else if (clk_en_i) begin
      case (pst_r)
        ST_RUN: begin
          // Reset-on-halt path leaves the counter running into reset
          if (halt_i && !(opt_reset_on_halt_i && active)) begin
            pst_r <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (ext_wake_i) begin
            pst_r <= ST_WAKE;
            wake_r <= 13'h0000;
          end
        end
        ST_WAKE: begin
          if (wake_r == WAKE_DELAY[12:0] - 13'h0001) begin
            pst_r <= ST_RUN;
          end else begin
            wake_r <= wake_r + 13'h0001;
          end
        end
        default: begin
          pst_r <= ST_RUN;
        end
      endcase
    end
  end

  // Reset pulse timer; a new trigger is ignored while one is running
  // low pulse width
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pulse_r <= 16'h0000;
      wdt_rst_n_o <= 1'b1;
    end else if (clk_en_i) begin
      if (pulse_r != 16'h0000) begin
        pulse_r <= pulse_r - 16'h0001;
        wdt_rst_n_o <= (pulse_r == 16'h0001);
      end else if (trigger) begin
        // Full count: the loading edge itself is the first low cycle
        pulse_r <= PULSE_CYC[15:0];
        wdt_rst_n_o <= 1'b0;
      end
    end
  end
endmodule // wdt_top

`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"
module tb_top;
  logic clk_i, rstn_i, hw, roh, halt, wake, awv, wv, br, arv, rr, g;
  logic [11:0] aw, ar;
  logic [31:0] wd, rd_d;
  logic [1:0] rd_r, bresp_d;
  logic ce;
  wire logic [1:0] bresp;
  wire logic awr, wrdy, bv, arr, rv, rst_n, act;
  wire logic [1:0] rresp;
  wire logic [31:0] rdat;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, w;
  // Short counts keep the run brief
  wdt_top #(.PRESCALE(8), .WAKE_DELAY(4), .PULSE_NS(40)) u_wdt_top (.clk_i(clk_i),
    .rstn_i(rstn_i), .clk_en_i(ce), .opt_hw_watchdog_i(hw), .opt_reset_on_halt_i(roh),
    .halt_i(halt), .ext_wake_i(wake), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .wdt_rst_n_o(rst_n),
    .wdt_active_o(act));
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rst();
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  // Handshakes judged on the values that stand at each rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    bresp_d = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arv && arr) arv <= 1'b0;
      rd_d = rdat;
      rd_r = rresp;
    end while (!rv);
    rr <= 1'b0;
  endtask
  // Wait for a reset pulse, then for its end
  task automatic pulse(input int lim);
    n = 0;
    while (rst_n === 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    w = n;
    g = (rst_n === 1'b0);
    n = 0;
    while (rst_n === 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic t_reset();
    rst();
    rd(12'h00c);
    chk("ctrl", rd_d, 32'h7f);
    rd(12'h010);
    chk("act", {31'h0, rd_d[0]}, 32'h0);
    rd(12'h004);
    chk("resp", {30'h0, rd_r}, {30'h0, `WDT_RESP_SLVERR});
    wr(12'h004, 32'h0);
    chk("bresp", {30'h0, bresp_d}, {30'h0, `WDT_RESP_SLVERR});
  endtask
  task automatic t_count();
    rst();
    wr(12'h00c, 32'h41);
    chk("wok", {30'h0, bresp_d}, {30'h0, `WDT_RESP_OKAY});
    // Enable low must freeze the count well past two steps
    ce <= 1'b0;
    repeat (40) @(posedge clk_i);
    ce <= 1'b1;
    rd(12'h00c);
    chk("frz", rd_d, 32'h41);
    rst();
    wr(12'h00c, 32'h41);
    pulse(17);
    chk("rst", {31'h0, g}, 32'h0);
    rd(12'h00c);
    chk("cnt", rd_d, 32'h3f);
  endtask
  task automatic t_active();
    rst();
    wr(12'h00c, 32'hc1);
    wr(12'h00c, 32'h41);
    rd(12'h00c);
    chk("ctrl", rd_d, 32'hc1);
    pulse(24);
    chk("rst", {31'h0, g}, 32'h1);
    chk("tmo", {31'h0, (w >= 8 && w <= 16)}, 32'h1);
    chk("len", n, 32'd10);
    rst();
    wr(12'h00c, 32'h80);
    pulse(6);
    chk("force", {31'h0, g}, 32'h1);
  endtask
  task automatic t_opts();
    rst();
    hw <= 1'b1;
    wr(12'h00c, 32'h41);
    chk("act", {31'h0, act}, 32'h1);
    pulse(24);
    chk("hw", {31'h0, g}, 32'h1);
    rst();
    hw <= 1'b0;
    roh <= 1'b1;
    wr(12'h00c, 32'hff);
    halt <= 1'b1;
    pulse(6);
    chk("halt", {31'h0, g}, 32'h1);
    halt <= 1'b0;
    roh <= 1'b0;
  endtask
  task automatic t_freeze();
    rst();
    wr(12'h00c, 32'hc1);
    halt <= 1'b1;
    pulse(30);
    chk("rst", {31'h0, g}, 32'h0);
    rd(12'h00c);
    chk("cnt", rd_d, 32'hc1);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    halt <= 1'b0;
    pulse(32);
    chk("wake", {31'h0, g}, 32'h1);
  endtask
  initial begin
    {rstn_i, hw, roh, halt, wake, awv, wv, br, arv, rr} = '0;
    aw = '0;
    ar = '0;
    wd = '0;
    ce = 1'b1;
    t_reset();
    t_count();
    t_active();
    t_opts();
    t_freeze();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

// >>> testbench/wdt_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"
// Port-level watch of the watchdog top
module wdt_top_sva #(parameter PULSE_NS = 30000) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic opt_hw_watchdog_i,
  input wire logic opt_reset_on_halt_i,
  input wire logic halt_i,
  input wire logic ext_wake_i,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic wdt_rst_n_o,
  input wire logic wdt_active_o
);
  logic [15:0] lo_r;
  logic ar_ok;
  // Read address accepted this edge
  assign ar_ok = s_axi_arvalid && s_axi_arready && clk_en_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Low cycles of the reset pulse so far
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) lo_r <= 16'h0;
    else lo_r <= wdt_rst_n_o ? 16'h0 : lo_r + 16'h1;
  end
  property p_len; $rose(wdt_rst_n_o) |-> lo_r == 16'(PULSE_NS / 4); endproperty
  property p_hw; opt_hw_watchdog_i |-> wdt_active_o; endproperty
  property p_keep; wdt_active_o && !opt_hw_watchdog_i |=> wdt_active_o; endproperty
  property p_cause; $fell(wdt_rst_n_o) |-> wdt_active_o; endproperty
  property p_halt;
    opt_reset_on_halt_i && wdt_active_o && $rose(halt_i) |-> ##[1:2] !wdt_rst_n_o;
  endproperty
  property p_frz;
    halt_i && !opt_reset_on_halt_i && !ext_wake_i && wdt_rst_n_o |=> wdt_rst_n_o;
  endproperty
  property p_rlat; ar_ok |=> s_axi_rvalid; endproperty
  property p_bad;
    ar_ok && s_axi_araddr != 12'h00c && s_axi_araddr != 12'h010
      |=> s_axi_rresp == `WDT_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_len: assert property (p_len) else $error("bad pulse length");
  a_hw: assert property (p_hw) else $error("hw option not active");
  a_keep: assert property (p_keep) else $error("activation lost");
  a_cause: assert property (p_cause) else $error("reset while inactive");
  a_halt: assert property (p_halt) else $error("no reset on halt");
  a_frz: assert property (p_frz) else $error("reset while halted");
  a_rlat: assert property (p_rlat) else $error("late read answer");
  a_bad: assert property (p_bad) else $error("unmapped read accepted");
  c_pulse: cover property ($fell(wdt_rst_n_o));
  c_wake: cover property (halt_i && ext_wake_i);
  c_bad: cover property (s_axi_rvalid && s_axi_rresp == `WDT_RESP_SLVERR);
endmodule // wdt_top_sva
bind wdt_top wdt_top_sva #(.PULSE_NS(PULSE_NS)) u_wdt_top_sva (.clk_i(clk_i),
  .rstn_i(rstn_i), .clk_en_i(clk_en_i), .opt_hw_watchdog_i(opt_hw_watchdog_i),
  .opt_reset_on_halt_i(opt_reset_on_halt_i), .halt_i(halt_i), .ext_wake_i(ext_wake_i),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .wdt_rst_n_o(wdt_rst_n_o), .wdt_active_o(wdt_active_o));
`default_nettype wire
